// ==== design/ghbp_host_ctrl.sv ====
// Purpose: Host-side controller driving a 16-bit generic host bus port of a display controller
// Assumes: Single user request at a time; device wait pin comes from another domain
// Notes: Models processor, chip-select decode and acknowledge glue as one block
`default_nettype none
module ghbp_host_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // User request and answer
    input wire logic reqValid,
    output logic reqReady,
    input wire ghbp_pkg::ghbp_req_s req,
    output logic rspValid,
    output ghbp_pkg::ghbp_rsp_s rsp,
    // Device pins
    output logic hostPortClock,
    output logic deviceReset_n,
    output logic [ghbp_pkg::ADDR_W-1:0] deviceAddr,
    input wire logic [ghbp_pkg::DATA_W-1:0] deviceDataIn,
    output logic [ghbp_pkg::DATA_W-1:0] deviceDataOut,
    output logic deviceDataOe,
    output ghbp_pkg::ghbp_strobe_s strobes,
    input wire logic deviceWait_n,
    output logic byteOrderStrap,
    output logic busStatusStrap_n,
    // Glue acknowledge towards processor
    output logic transferAck_n,
    output logic transferAckOe
);
    localparam int DIV_W = 8;
    localparam int WCNT_W = 11;

    // Device pins run on the divided port clock; strobes and reset change at its falling edge, address, data and acknowledge do not
    logic [DIV_W-1:0] divCnt_q, divCnt_d;
    logic portClk_q, portClk_d;
    logic fallEdge;
    logic riseEdge;
    logic [1:0] rstCnt_q, rstCnt_d;

    always_comb begin
        divCnt_d = divCnt_q + 8'h01;
        portClk_d = portClk_q;
        rstCnt_d = rstCnt_q;
        if (divCnt_q == DIV_W'(ghbp_pkg::PORT_CLK_HALF_DIV - 1)) begin
            divCnt_d = 8'h00;
            portClk_d = ~portClk_q;
        end
        if (fallEdge && rstCnt_q != 2'h3) begin
            rstCnt_d = rstCnt_q + 2'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q <= 8'h00;
            portClk_q <= 1'b0;
            rstCnt_q <= 2'h0;
        end else begin
            divCnt_q <= divCnt_d;
            portClk_q <= portClk_d;
            rstCnt_q <= rstCnt_d;
        end
    end

    assign fallEdge = portClk_q && divCnt_q == DIV_W'(ghbp_pkg::PORT_CLK_HALF_DIV - 1);
    assign riseEdge = !portClk_q && divCnt_q == DIV_W'(ghbp_pkg::PORT_CLK_HALF_DIV - 1);
    assign hostPortClock = portClk_q;
    // Straps are steady from reset, so the device samples them on its reset release
    assign deviceReset_n = rstCnt_q == 2'h3;
    assign byteOrderStrap = ghbp_pkg::BYTE_ORDER_BIG;
    assign busStatusStrap_n = ghbp_pkg::BUS_STATUS_GENERIC;

    // Wait pin synchroniser
    logic waitMeta_q, waitSync_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            waitMeta_q <= 1'b1;
            waitSync_q <= 1'b1;
        end else begin
            waitMeta_q <= deviceWait_n;
            waitSync_q <= waitMeta_q;
        end
    end

    ghbp_pkg::ghbp_state_e state_q, state_d;
    ghbp_pkg::ghbp_req_s cur_q, cur_d;
    ghbp_pkg::ghbp_strobe_s strobe_q, strobe_d;
    logic [ghbp_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic timeout_q, timeout_d;
    logic rspValid_q, rspValid_d;
    logic ack_q, ack_d;
    logic [WCNT_W-1:0] waitCnt_q, waitCnt_d;

    function automatic ghbp_pkg::ghbp_strobe_s lane_strobes(input logic wr, input logic [1:0] ln);
        ghbp_pkg::ghbp_strobe_s s;
        s.chipSelect_n = 1'b0;
        s.lowByteWriteStrobe_n = !(wr && ln[0]);
        s.highByteWriteStrobe_n = !(wr && ln[1]);
        s.lowByteReadStrobe_n = !(!wr && ln[0]);
        s.highByteReadStrobe_n = !(!wr && ln[1]);
        return s;
    endfunction

    localparam ghbp_pkg::ghbp_strobe_s STROBE_IDLE = 5'h1f;

    always_comb begin
        state_d = state_q;
        cur_d = cur_q;
        strobe_d = strobe_q;
        rdata_d = rdata_q;
        timeout_d = timeout_q;
        rspValid_d = 1'b0;
        ack_d = 1'b0;
        waitCnt_d = waitCnt_q;
        unique case (state_q)
            ghbp_pkg::ST_IDLE: begin
                // A request is refused while the device is still held in reset
                if (reqValid && deviceReset_n) begin
                    cur_d = req;
                    state_d = ghbp_pkg::ST_SETUP;
                end
            end
            ghbp_pkg::ST_SETUP: begin
                // Address settles before strobes, which wait for the next port clock falling edge
                if (fallEdge) begin
                    strobe_d = lane_strobes(cur_q.write, cur_q.lanes);
                    waitCnt_d = '0;
                    state_d = ghbp_pkg::ST_STROBE;
                end
            end
            ghbp_pkg::ST_STROBE: begin
                // Give the device one port clock to pull wait low
                if (fallEdge) begin
                    state_d = ghbp_pkg::ST_WAIT;
                end
            end
            ghbp_pkg::ST_WAIT: begin
                if (riseEdge) begin
                    if (waitSync_q) begin
                        rdata_d = deviceDataIn;
                        timeout_d = 1'b0;
                        state_d = ghbp_pkg::ST_ACK;
                    end else if (waitCnt_q == WCNT_W'(ghbp_pkg::WAIT_LIMIT)) begin
                        // Escape hatch: a stuck device must not hang the user side
                        timeout_d = 1'b1;
                        state_d = ghbp_pkg::ST_ACK;
                    end else begin
                        waitCnt_d = waitCnt_q + 11'h001;
                    end
                end
            end
            ghbp_pkg::ST_ACK: begin
                // Acknowledge stands until the port clock falls, then the cycle closes
                // A timed-out cycle never saw wait released, so it ends with no acknowledge
                ack_d = !timeout_q;
                if (fallEdge) begin
                    strobe_d = STROBE_IDLE;
                    rspValid_d = 1'b1;
                    state_d = ghbp_pkg::ST_RELEASE;
                end
            end
            ghbp_pkg::ST_RELEASE: begin
                // Idle port clock lets acknowledge and wait release before the next cycle
                if (fallEdge) begin
                    state_d = ghbp_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ghbp_pkg::ST_IDLE;
            cur_q <= '0;
            strobe_q <= 5'h1f;
            rdata_q <= 16'h0000;
            timeout_q <= 1'b0;
            rspValid_q <= 1'b0;
            ack_q <= 1'b0;
            waitCnt_q <= 11'h000;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            strobe_q <= strobe_d;
            rdata_q <= rdata_d;
            timeout_q <= timeout_d;
            rspValid_q <= rspValid_d;
            ack_q <= ack_d;
            waitCnt_q <= waitCnt_d;
        end
    end

    assign reqReady = state_q == ghbp_pkg::ST_IDLE && deviceReset_n;
    assign rspValid = rspValid_q;
    assign rsp.rdata = rdata_q;
    assign rsp.timeout = timeout_q;
    assign strobes = strobe_q;
    assign deviceAddr = cur_q.addr;
    assign deviceDataOut = cur_q.wdata;
    assign deviceDataOe = cur_q.write && !strobe_q.chipSelect_n;
    assign transferAck_n = !ack_q;
    assign transferAckOe = !strobe_q.chipSelect_n;
endmodule // ghbp_host_ctrl
`default_nettype wire

// ==== design/ghbp_pkg.sv ====
// Purpose: Shared constants and carriers for the generic host bus port controller
// Assumes: 100 MHz controller clock, 17-bit device address, 16-bit device data
// Notes: Controller drives the device pins; device registers are not modelled here
package ghbp_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 10;
    // Host port clock is the controller clock divided by 2*HALF_DIV
    localparam int PORT_CLK_HALF_DIV = 2;
    // Longest wait for device wait release, in port clock periods
    localparam int WAIT_LIMIT = 1024;
    localparam logic [1:0] LANE_NONE = 2'h0;
    localparam logic [1:0] LANE_LOW = 2'h1;
    localparam logic [1:0] LANE_HIGH = 2'h2;
    localparam logic BYTE_ORDER_BIG = 1'b1;
    localparam logic BUS_STATUS_GENERIC = 1'b0;

    typedef struct packed {
        logic write;
        logic [1:0] lanes;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ghbp_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic timeout;
    } ghbp_rsp_s;

    typedef struct packed {
        logic chipSelect_n;
        logic lowByteReadStrobe_n;
        logic highByteReadStrobe_n;
        logic lowByteWriteStrobe_n;
        logic highByteWriteStrobe_n;
    } ghbp_strobe_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_WAIT,
        ST_ACK,
        ST_RELEASE
    } ghbp_state_e;
endpackage : ghbp_pkg

// ==== test/ghbp_host_ctrl_properties.sv ====
// Purpose: Port-level checks for ghbp_host_ctrl
// Assumes: Port clock is the controller clock divided by four
// Notes: Bound to every controller instance
`default_nettype none
module ghbp_host_ctrl_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Observed pins
    input wire logic hostPortClock,
    input wire ghbp_pkg::ghbp_strobe_s strobes,
    input wire logic deviceWait_n,
    input wire logic byteOrderStrap,
    input wire logic transferAck_n,
    input wire logic transferAckOe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Acknowledge stays low for two controller clocks, then releases
    sequence s_ackPulse; !transferAck_n[*2] ##1 $rose(transferAck_n); endsequence
    property p_ackPulse; $fell(transferAck_n) |-> s_ackPulse; endproperty
    a_ackPulse: assert property (p_ackPulse) else $error("ack pulse length");
    property p_ackFromWait; $fell(transferAck_n) |-> $past(deviceWait_n, 2); endproperty
    a_ackFromWait: assert property (p_ackFromWait) else $error("ack without wait release");
    property p_ackEnable; transferAckOe == !strobes.chipSelect_n; endproperty
    a_ackEnable: assert property (p_ackEnable) else $error("ack enable off select");
    property p_ackUnderSelect; $fell(transferAck_n) |-> transferAckOe; endproperty
    a_ackUnderSelect: assert property (p_ackUnderSelect) else $error("ack outside select");
    property p_strobeUnderSelect; strobes.chipSelect_n |-> &strobes[3:0]; endproperty
    a_strobeUnderSelect: assert property (p_strobeUnderSelect) else $error("stray strobe");
    property p_readWriteApart; &strobes[3:2] || &strobes[1:0]; endproperty
    a_readWriteApart: assert property (p_readWriteApart) else $error("read and write");
    property p_selectHold; $fell(strobes.chipSelect_n) |-> !strobes.chipSelect_n[*4]; endproperty
    a_selectHold: assert property (p_selectHold) else $error("select too short");
    property p_portClock; $rose(hostPortClock) |-> ##4 $rose(hostPortClock); endproperty
    a_portClock: assert property (p_portClock) else $error("port clock period");
    property p_byteOrder; byteOrderStrap == ghbp_pkg::BYTE_ORDER_BIG; endproperty
    a_byteOrder: assert property (p_byteOrder) else $error("byte order strap");
endmodule : ghbp_host_ctrl_properties
bind ghbp_host_ctrl ghbp_host_ctrl_properties u_props (.clock(clock), .rst_n(rst_n),
    .hostPortClock(hostPortClock), .strobes(strobes), .deviceWait_n(deviceWait_n),
    .byteOrderStrap(byteOrderStrap), .transferAck_n(transferAck_n),
    .transferAckOe(transferAckOe));
`default_nettype wire

// ==== test/ghbp_device_model.sv ====
// Purpose: Behavioural display device behind the generic host port
// Assumes: Wait delay in port clocks is set by the bench
// Notes: Only 256 words are kept, so addresses alias
`default_nettype none
module ghbp_device_model (
    // Host port pins
    input wire logic hostPortClock,
    input wire logic [16:0] deviceAddr,
    input wire logic [15:0] deviceDataOut,
    input wire logic deviceDataOe,
    input wire ghbp_pkg::ghbp_strobe_s strobes,
    output logic [15:0] deviceDataIn,
    output logic deviceWait_n,
    // Bench control
    input wire logic [11:0] waitCycles
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [256];
    int cnt = 0;
    wire logic sel = !strobes.chipSelect_n;
    wire logic [15:0] word = mem[deviceAddr[7:0]];
    wire logic [15:0] rdMask = ~{{8{strobes[2]}}, {8{strobes[3]}}};
    initial foreach (mem[i]) mem[i] = '0;
    // Undriven lanes show inverted data so a stale value never passes
    assign deviceDataIn = deviceDataOe ? deviceDataOut : sel ? word ^ ~rdMask : ~word;
    assign deviceWait_n = !sel || cnt > waitCycles;
    always @(posedge hostPortClock) begin
        cnt <= sel ? cnt + 1 : 0;
        if (sel && cnt == waitCycles) begin
            if (!strobes[1]) mem[deviceAddr[7:0]][7:0] <= deviceDataOut[7:0];
            if (!strobes[0]) mem[deviceAddr[7:0]][15:8] <= deviceDataOut[15:8];
        end
    end
endmodule : ghbp_device_model
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Self-checking bench for ghbp_host_ctrl
// Assumes: Device model releases wait after waitCycles+1 port clocks
// Notes: Reference memory mirrors the device per byte lane
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 0, rst_n = 0, reqValid = 0, reqReady, rspValid;
    ghbp_pkg::ghbp_req_s req = '0;
    ghbp_pkg::ghbp_rsp_s rsp;
    ghbp_pkg::ghbp_strobe_s strobes;
    logic pClk, devRst_n, oe, wait_n, bigEnd, bs_n, ack_n, ackOe;
    logic [16:0] addr;
    logic [15:0] dIn, dOut;
    logic [11:0] waitCycles = '0;
    int mismatches = 0, total_checks = 0;
    int refMem [256] = '{default: 0};
    logic [16:0] expQ [$];
    ghbp_host_ctrl u_ghbp_host_ctrl (.clock(clock), .rst_n(rst_n), .reqValid(reqValid),
        .reqReady(reqReady), .req(req), .rspValid(rspValid), .rsp(rsp), .hostPortClock(pClk),
        .deviceReset_n(devRst_n), .deviceAddr(addr), .deviceDataIn(dIn), .deviceDataOut(dOut),
        .deviceDataOe(oe), .strobes(strobes), .deviceWait_n(wait_n), .byteOrderStrap(bigEnd),
        .busStatusStrap_n(bs_n), .transferAck_n(ack_n), .transferAckOe(ackOe));
    ghbp_device_model u_ghbp_device_model (.hostPortClock(pClk), .deviceAddr(addr),
        .deviceDataOut(dOut), .deviceDataOe(oe), .strobes(strobes), .deviceDataIn(dIn),
        .deviceWait_n(wait_n), .waitCycles(waitCycles));
    initial forever #5 clock = ~clock;
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic access(input logic w, input logic [1:0] ln, input logic [16:0] a,
            input logic [15:0] d, input logic tmo);
        logic [15:0] m;
        int i;
        m = {{8{ln[1]}}, {8{ln[0]}}};
        if (w) refMem[a[7:0]] = refMem[a[7:0]] & ~m | d & m;
        // Write data and timed-out reads carry no meaningful read word
        if (w || tmo) m = '0;
        expQ.push_back({16'(refMem[a[7:0]]) & m, tmo});
        @(posedge clock);
        for (i = 0; i < 200 && reqReady !== 1'b1; i++) @(posedge clock);
        reqValid <= 1;
        req <= '{w, ln, a, d};
        @(posedge clock);
        reqValid <= 0;
        for (i = 0; i < 6000 && rspValid !== 1'b1; i++) @(posedge clock);
        check({rsp.rdata & m, rsp.timeout}, expQ.pop_front());
        check(addr, a);
        if (w) check(17'(dOut), 17'(d));
    endtask
    initial begin
        void'($urandom(73));
        repeat (11) @(posedge clock);
        check({strobes, ackOe, bs_n, bigEnd, devRst_n}, 17'h1f2);
        @(posedge clock);
        rst_n <= 1;
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            access(1, k[1:0], 17'h10 + 17'(k), 16'ha5c3 ^ 16'(k), 0);
            access(0, 2'h3, 17'h10 + 17'(k), 16'h0, 0);
        end
        $display("test lanes done");
        repeat (24) begin
            waitCycles <= 12'($urandom_range(0, 12));
            access(1'($urandom), 2'($urandom), 17'($urandom) & 17'h1f00f, 16'($urandom), 0);
        end
        $display("test random done");
        waitCycles <= 12'h44c;
        access(0, 2'h3, 17'h3, 16'h0, 1);
        waitCycles <= 12'h0;
        access(0, 2'h3, 17'h3, 16'h0, 0);
        $display("test timeout done");
        summarize();
    end
    initial begin
        repeat (60000) @(posedge clock);
        mismatches++;
        summarize();
    end
endmodule : tb
`default_nettype wire
